// ===== hw/conv_cfg.svh
/*
 * Offsets, reset values and counts of the converter mode controller.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CONV_CFG_SVH
`define CONV_CFG_SVH

`define PIN_COUNT          11
`define PIN_TURN_ON        0
`define PIN_INPUT_LOW      1
`define PIN_INPUT_HIGH     2
`define PIN_ANALOG_RESET   3
`define PIN_PRI_HOT        4
`define PIN_SEC_HOT        5
`define PIN_POS_LOW        6
`define PIN_NEG_LOW        7
`define PIN_POS_OVER       8
`define PIN_NEG_OVER       9
`define PIN_FAILSAFE_OVER  10

`define ADDR_STEP          32'h0000_0000
`define ADDR_STATUS        32'h0000_0004
`define ADDR_INT_STATUS    32'h0000_0008
`define ADDR_INT_ENABLE    32'h0000_000C
`define ADDR_INT_CLEAR     32'h0000_0010

`define STEP_RESET         16'h0004
`define INT_ENABLE_RESET   4'h0
`define INT_COUNT          4
`define INT_LATCHED        0
`define INT_LOCKOUT        1
`define INT_NORMAL         2
`define INT_OVERHEAT       3

`define LEVEL_FULL         8'hFF
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== hw/conv_pkg.sv
/*
 * Types of the converter mode controller.
 * Assumes nothing of its surroundings.
 */
package conv_pkg;

    typedef enum logic [4:0] {
        ST_DISABLE    = 5'b0_0001,
        ST_SOFT_START = 5'b0_0010,
        ST_NORMAL     = 5'b0_0100,
        ST_AUTO_RECOV = 5'b0_1000,
        ST_LATCHED    = 5'b1_0000
    } mode_t;

endpackage : conv_pkg

// ===== hw/ramp_if.sv
/*
 * Link between mode controller and soft-start ramp.
 * Assumes both ends on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface ramp_if;
    logic        run;
    logic [15:0] step_cycles;
    logic [7:0]  level;
    logic        done;

    modport ctrl (output run, output step_cycles, input level, input done);
    modport ramp (input run, input step_cycles, output level, output done);
endinterface : ramp_if

`default_nettype wire

// ===== hw/pin_sync.sv
/*
 * Two-stage synchronisers for asynchronous comparator and request pins.
 * Assumes pins are static levels relative to the clock.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] pins,
    output var  logic [WIDTH-1:0] synced
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic first;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    first     <= 1'b0;
                    synced[i] <= 1'b0;
                end else begin
                    first     <= pins[i];
                    synced[i] <= first;
                end
            end
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ===== hw/soft_start_ramp.sv
/*
 * Soft-start ramp: level climbs one step every step_cycles+1 cycles.
 * Assumes run is held high for the whole soft-start.
 */
`timescale 1ns/10ps
`default_nettype none
`include "conv_cfg.svh"

module soft_start_ramp (
    input  wire logic aclk,
    input  wire logic aresetn,
    ramp_if.ramp      rp
);

    logic [15:0] prescale;
    logic [15:0] next_prescale;
    logic [7:0]  level;
    logic [7:0]  next_level;

    always_comb begin
        next_prescale = prescale;
        next_level    = level;
        if (!rp.run) begin
            next_prescale = 16'h0000;
            next_level    = 8'h00;
        end else if (level != `LEVEL_FULL) begin
            if (prescale >= rp.step_cycles) begin
                next_prescale = 16'h0000;
                next_level    = level + 8'h01;
            end else begin
                next_prescale = prescale + 16'h0001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= 16'h0000;
            level    <= 8'h00;
        end else begin
            prescale <= next_prescale;
            level    <= next_level;
        end
    end

    assign rp.level = level;
    assign rp.done  = (level == `LEVEL_FULL);

endmodule : soft_start_ramp

`default_nettype wire

// ===== hw/converter_mode_protection_fsm.sv
/*
 * Mode and protection controller of an isolated converter, with an
 * AXI4-Lite register slave and one level interrupt.
 * Assumes comparator pins arrive asynchronously, aclk at 100 MHz.
 */
`timescale 1ns/10ps
`default_nettype none
`include "conv_cfg.svh"

module converter_mode_protection_fsm (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        turn_on_request,
    input  wire logic        input_low_lockout,
    input  wire logic        input_high_lockout,
    input  wire logic        analog_input_low_reset,
    input  wire logic        primary_overheat_limit,
    input  wire logic        secondary_overheat_limit,
    input  wire logic        positive_rail_low,
    input  wire logic        negative_rail_low,
    input  wire logic        positive_rail_over,
    input  wire logic        negative_rail_over,
    input  wire logic        failsafe_over,
    output var  logic        switch_enable,
    output var  logic [7:0]  duty_level,
    output var  logic [7:0]  ref_level,
    output var  logic        supply_good_n_out,
    output var  logic        supply_good_n_oe,
    output var  logic        irq,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    logic [`PIN_COUNT-1:0] pins;
    logic [`PIN_COUNT-1:0] sy;

    assign pins = {failsafe_over, negative_rail_over, positive_rail_over,
                   negative_rail_low, positive_rail_low,
                   secondary_overheat_limit, primary_overheat_limit,
                   analog_input_low_reset, input_high_lockout,
                   input_low_lockout, turn_on_request};

    pin_sync #(.WIDTH(`PIN_COUNT)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pins),
        .synced  (sy)
    );

    logic req;
    logic out_of_window;
    logic overheat;
    logic rail_low;
    logic rail_over;

    assign req           = sy[`PIN_TURN_ON];
    assign out_of_window = sy[`PIN_INPUT_LOW] | sy[`PIN_INPUT_HIGH];
    assign overheat      = sy[`PIN_PRI_HOT] | sy[`PIN_SEC_HOT];
    assign rail_low      = sy[`PIN_POS_LOW] | sy[`PIN_NEG_LOW];
    assign rail_over     = sy[`PIN_POS_OVER] | sy[`PIN_NEG_OVER]
                         | sy[`PIN_FAILSAFE_OVER];

    // ****************************************************************
    // Soft-start ramp
    // ****************************************************************
    ramp_if rif ();
    logic [15:0] step_cycles;

    soft_start_ramp u_ramp (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rp      (rif.ramp)
    );

    // ****************************************************************
    // Mode state machine
    // ****************************************************************
    conv_pkg::mode_t state;
    conv_pkg::mode_t next_state;
    logic            seen_low;
    logic            next_seen_low;
    logic [2:0]      cause;
    logic [2:0]      next_cause;
    logic [`INT_COUNT-1:0] events;

    always_comb begin
        next_state    = state;
        next_seen_low = seen_low;
        next_cause    = cause;
        events        = '0;
        case (state)
            conv_pkg::ST_DISABLE: begin
                if (out_of_window) begin
                    next_state = conv_pkg::ST_AUTO_RECOV;
                end else if (overheat) begin
                    next_state = conv_pkg::ST_LATCHED;
                    next_cause = 3'b001;
                end else if (req) begin
                    next_state = conv_pkg::ST_SOFT_START;
                end
            end
            conv_pkg::ST_SOFT_START, conv_pkg::ST_NORMAL: begin
                if (out_of_window) begin
                    next_state = conv_pkg::ST_AUTO_RECOV;
                end else if (overheat) begin
                    next_state = conv_pkg::ST_LATCHED;
                    next_cause = 3'b001;
                end else if (rail_over) begin
                    next_state = conv_pkg::ST_LATCHED;
                    next_cause = 3'b010;
                end else if (!req) begin
                    next_state = conv_pkg::ST_DISABLE;
                end else if (state == conv_pkg::ST_NORMAL) begin
                    if (rail_low) begin
                        next_state = conv_pkg::ST_LATCHED;
                        next_cause = 3'b100;
                    end
                end else if (rif.done) begin
                    if (rail_low) begin
                        next_state = conv_pkg::ST_LATCHED;
                        next_cause = 3'b100;
                    end else begin
                        next_state = conv_pkg::ST_NORMAL;
                    end
                end
            end
            conv_pkg::ST_AUTO_RECOV: begin
                if (!out_of_window) begin
                    next_state = req ? conv_pkg::ST_SOFT_START
                                     : conv_pkg::ST_DISABLE;
                end
            end
            conv_pkg::ST_LATCHED: begin
                // Input high lockout alone never reaches here
                if (!req) begin
                    next_seen_low = 1'b1;
                end
                if (sy[`PIN_ANALOG_RESET]) begin
                    next_state    = conv_pkg::ST_AUTO_RECOV;
                    next_seen_low = 1'b0;
                    next_cause    = 3'b000;
                end else if (seen_low && req && !overheat) begin
                    next_state    = conv_pkg::ST_SOFT_START;
                    next_seen_low = 1'b0;
                    next_cause    = 3'b000;
                end
            end
            default: begin
                next_state = conv_pkg::ST_AUTO_RECOV;
            end
        endcase
        if (next_state != state) begin
            events[`INT_LATCHED] = (next_state == conv_pkg::ST_LATCHED);
            events[`INT_LOCKOUT] = (next_state == conv_pkg::ST_AUTO_RECOV);
            events[`INT_NORMAL]  = (next_state == conv_pkg::ST_NORMAL);
            events[`INT_OVERHEAT] = (next_state == conv_pkg::ST_LATCHED)
                                  && next_cause[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state    <= conv_pkg::ST_AUTO_RECOV;
            seen_low <= 1'b0;
            cause    <= 3'b000;
        end else begin
            state    <= next_state;
            seen_low <= next_seen_low;
            cause    <= next_cause;
        end
    end

    assign rif.run         = (state == conv_pkg::ST_SOFT_START);
    assign rif.step_cycles = step_cycles;

    // ****************************************************************
    // Power stage outputs
    // ****************************************************************
    logic       next_switch;
    logic [7:0] next_level;

    always_comb begin
        next_switch = (next_state == conv_pkg::ST_SOFT_START)
                    || (next_state == conv_pkg::ST_NORMAL);
        if (next_state == conv_pkg::ST_NORMAL) begin
            next_level = `LEVEL_FULL;
        end else if (next_state == conv_pkg::ST_SOFT_START) begin
            next_level = rif.level;
        end else begin
            next_level = 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            switch_enable     <= 1'b0;
            duty_level        <= 8'h00;
            ref_level         <= 8'h00;
            supply_good_n_out <= 1'b0;
            supply_good_n_oe  <= 1'b0;
        end else begin
            switch_enable     <= next_switch;
            duty_level        <= next_level;
            ref_level         <= next_level;
            supply_good_n_out <= 1'b0;
            supply_good_n_oe  <= (next_state == conv_pkg::ST_NORMAL);
        end
    end

    // ****************************************************************
    // Register slave and interrupts
    // ****************************************************************
    logic        aw_held, next_aw_held;
    logic        w_held, next_w_held;
    logic [31:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;
    logic [15:0] next_step;
    logic [`INT_COUNT-1:0] int_status, next_int_status;
    logic [`INT_COUNT-1:0] int_enable, next_int_enable;
    logic [`INT_COUNT-1:0] clear;

    always_comb begin
        next_aw_held    = aw_held;
        next_w_held     = w_held;
        next_aw_addr    = aw_addr;
        next_w_data     = w_data;
        next_w_strb     = w_strb;
        next_bvalid     = s_axi_bvalid;
        next_bresp      = s_axi_bresp;
        next_rvalid     = s_axi_rvalid;
        next_rdata      = s_axi_rdata;
        next_rresp      = s_axi_rresp;
        next_step       = step_cycles;
        next_int_enable = int_enable;
        clear           = '0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = `RESP_OKAY;
            case (aw_addr)
                `ADDR_STEP: begin
                    if (w_strb[0]) next_step[7:0] = w_data[7:0];
                    if (w_strb[1]) next_step[15:8] = w_data[15:8];
                end
                `ADDR_INT_ENABLE: begin
                    if (w_strb[0]) next_int_enable = w_data[`INT_COUNT-1:0];
                end
                `ADDR_INT_CLEAR: begin
                    if (w_strb[0]) clear = w_data[`INT_COUNT-1:0];
                end
                `ADDR_STATUS, `ADDR_INT_STATUS: begin
                end
                default: begin
                    next_bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = `RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                `ADDR_STEP:       next_rdata[15:0] = step_cycles;
                `ADDR_STATUS:     next_rdata[11:0] = {req, seen_low,
                                      cause, state, switch_enable, 1'b0};
                `ADDR_INT_STATUS: next_rdata[`INT_COUNT-1:0] = int_status;
                `ADDR_INT_ENABLE: next_rdata[`INT_COUNT-1:0] = int_enable;
                `ADDR_INT_CLEAR:  next_rdata = 32'h0000_0000;
                default:          next_rresp = `RESP_SLVERR;
            endcase
        end
        // Set wins over a clear in the same cycle
        next_int_status = (int_status & ~clear) | events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 32'h0000_0000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
            step_cycles   <= `STEP_RESET;
            int_status    <= '0;
            int_enable    <= `INT_ENABLE_RESET;
            irq           <= 1'b0;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            step_cycles   <= next_step;
            int_status    <= next_int_status;
            int_enable    <= next_int_enable;
            irq           <= |(next_int_status & next_int_enable);
        end
    end

endmodule : converter_mode_protection_fsm

`default_nettype wire

// ===== test/conv_host_model.sv
/* Host side model: drives the turn-on request, reads power-good.
   Assumes a pull-up on the open-drain power-good pin. */
`timescale 1ns/10ps
`default_nettype none
module conv_host_model #(
    parameter int HOLD = 15100
) (
    input  wire logic aclk,
    input  wire logic supply_good_n_oe,
    output var  logic turn_on_request,
    output wire logic supply_good_n
);
    // ****
    // Request pin and pulled-up status pin
    // ****
    initial turn_on_request = 1'h0;
    assign supply_good_n = !supply_good_n_oe;
    task automatic drive(input logic v);
        @(posedge aclk);
        turn_on_request <= v;
    endtask : drive
    // Low phase long enough to clear a latch
    task automatic hold_low();
        drive(1'h0);
        repeat (HOLD) @(posedge aclk);
    endtask : hold_low
endmodule : conv_host_model
`default_nettype wire

// ===== test/conv_mode_monitor.sv
/* Port-level checks of the converter mode controller.
   Assumes binding onto the controller top module. */
`timescale 1ns/10ps
`default_nettype none
module conv_mode_monitor (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       turn_on_request,
    input wire logic       input_low_lockout,
    input wire logic       input_high_lockout,
    input wire logic       primary_overheat_limit,
    input wire logic       secondary_overheat_limit,
    input wire logic       positive_rail_over,
    input wire logic       negative_rail_over,
    input wire logic       failsafe_over,
    input wire logic       switch_enable,
    input wire logic [7:0] duty_level,
    input wire logic [7:0] ref_level,
    input wire logic       supply_good_n_out,
    input wire logic       supply_good_n_oe
);
    // ****
    // Mode checks
    // ****
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence hot_5;
        (primary_overheat_limit || secondary_overheat_limit) [*5];
    endsequence
    sequence over_5;
        (positive_rail_over || negative_rail_over || failsafe_over) [*5];
    endsequence
    sequence ramp_start;
        !switch_enable ##1 switch_enable;
    endsequence
    chk_hot_stops: assert property (
        hot_5 |-> !switch_enable && !supply_good_n_oe)
        else $error("switching during overheat");
    chk_over_stops: assert property (
        over_5 |-> !switch_enable) else $error("switching in overvoltage");
    chk_window_off: assert property (
        (input_low_lockout || input_high_lockout) [*5] |-> !switch_enable)
        else $error("switching outside supply window");
    chk_req_low_off: assert property (
        !turn_on_request [*5] |-> !switch_enable)
        else $error("switching without request");
    chk_good_normal: assert property (
        supply_good_n_oe |-> switch_enable && duty_level == 8'hFF
        && !supply_good_n_out) else $error("power-good outside normal");
    chk_off_quiet: assert property (
        !switch_enable [*3] |-> duty_level == 8'h00 && ref_level == 8'h00)
        else $error("ramp level while off");
    chk_ramp_climbs: assert property (
        switch_enable && $past(switch_enable) |->
        duty_level >= $past(duty_level)) else $error("ramp fell");
    chk_ramp_first: assert property (
        ramp_start |-> !supply_good_n_oe [*8])
        else $error("normal without soft-start");
endmodule : conv_mode_monitor
bind converter_mode_protection_fsm conv_mode_monitor u_mon (
    .aclk, .aresetn, .turn_on_request, .input_low_lockout,
    .input_high_lockout, .primary_overheat_limit, .secondary_overheat_limit,
    .positive_rail_over, .negative_rail_over, .failsafe_over, .switch_enable,
    .duty_level, .ref_level, .supply_good_n_out, .supply_good_n_oe);
`default_nettype wire

// ===== test/converter_mode_protection_fsm_test.sv
/* Self-checking bench of the converter mode controller.
   Assumes the host model and the bound port monitor. */
`timescale 1ns/10ps
`default_nettype none
`include "conv_cfg.svh"
`define CHK(a, e, s) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH %0t %s", $time, s); end end
module converter_mode_protection_fsm_test;
    // ****
    // Bench state
    // ****
    logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0;
    logic        s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_arvalid = 1'h0, switch_enable, irq, turn_on_request;
    logic        supply_good_n, supply_good_n_out, supply_good_n_oe;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid;
    logic [10:0] pin = 11'h000;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_rdata;
    logic [7:0]  duty_level, ref_level;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          err_total = 0, checks = 0, m = 8, cyc = 0, seed = 31239;
    bit          seen_low;
    converter_mode_protection_fsm u_dut (
        .aclk, .aresetn, .turn_on_request, .switch_enable, .duty_level,
        .ref_level, .supply_good_n_out, .supply_good_n_oe, .irq,
        .input_low_lockout(pin[1]), .input_high_lockout(pin[2]),
        .analog_input_low_reset(pin[3]), .primary_overheat_limit(pin[4]),
        .secondary_overheat_limit(pin[5]), .positive_rail_low(pin[6]),
        .negative_rail_low(pin[7]), .positive_rail_over(pin[8]),
        .negative_rail_over(pin[9]), .failsafe_over(pin[10]),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    conv_host_model u_host (
        .aclk, .supply_good_n_oe, .turn_on_request, .supply_good_n);
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            finish_test();
        end
    end
    // Reference mode model: 1 off, 2 ramp, 4 normal, 8 lockout, 16 latched
    function automatic int model(int s);
        bit q, hot;
        q = turn_on_request;
        hot = pin[4] | pin[5];
        if (s == 16) begin
            if (pin[3]) return 8;
            if (!q) seen_low = 1;
            return (seen_low && q && !hot) ? 2 : 16;
        end
        seen_low = 0;
        if (pin[1] | pin[2]) return 8;
        if (s == 8) return q ? 2 : 1;
        if (hot | (|pin[10:8])) return 16;
        if (!q) return 1;
        if (s == 4 && |pin[7:6]) return 16;
        return (s == 1) ? 2 : s;
    endfunction : model
    task automatic xfer(input bit w, input logic [31:0] a, d,
                        input logic [1:0] er, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 50);
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        r = s_axi_rdata;
        `CHK({n < 50, w ? s_axi_bresp : s_axi_rresp}, {1'h1, er}, "response")
    endtask : xfer
    task automatic settle(input int c, input bit ramp_end);
        logic [31:0] r;
        repeat (c) @(posedge aclk);
        repeat (3) m = model(m);
        if (ramp_end && m == 2) m = (|pin[7:6]) ? 16 : 4;
        xfer(0, `ADDR_STATUS, 0, `RESP_OKAY, r);
        `CHK(r[6:2], 5'(m), "mode")
        `CHK(r[1], 1'(m == 2 || m == 4), "switching")
        `CHK(supply_good_n, 1'(m != 4), "power-good pin")
    endtask : settle
    task automatic finish_test();
        $display("checks %0d, err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    // ****
    // Scenarios
    // ****
    initial begin
        logic [31:0] r;
        logic [15:0] v;
        int flt[5] = '{4, 5, 8, 9, 10};
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        settle(8, 0);
        xfer(0, `ADDR_STEP, 0, `RESP_OKAY, r);
        `CHK(r[15:0], `STEP_RESET, "step reset")
        xfer(0, `ADDR_INT_ENABLE, 0, `RESP_OKAY, r);
        `CHK(r[3:0], `INT_ENABLE_RESET, "enable reset")
        xfer(1, 32'h0000_0020, 0, `RESP_SLVERR, r);
        xfer(0, 32'h0000_0020, 0, `RESP_SLVERR, r);
        `CHK(r, 32'h0000_0000, "unmapped read")
        v = 16'($random(seed));
        xfer(1, `ADDR_STEP, {16'h0000, v}, `RESP_OKAY, r);
        xfer(0, `ADDR_STEP, 0, `RESP_OKAY, r);
        `CHK(r[15:0], v, "step readback")
        xfer(1, `ADDR_STEP, 32'h0000_0004, `RESP_OKAY, r);
        xfer(1, `ADDR_INT_CLEAR, 32'h0000_000F, `RESP_OKAY, r);
        $display("test registers done");
        pin <= 11'h040;
        u_host.drive(1'h1);
        settle(8, 0);
        `CHK({duty_level < 8'hFF, ref_level < 8'hFF}, 2'h3, "ramp part")
        pin <= 11'h000;
        settle(1400, 1);
        xfer(0, `ADDR_INT_STATUS, 0, `RESP_OKAY, r);
        `CHK({irq, r[3:0]}, 5'h04, "normal event masked")
        xfer(1, `ADDR_INT_ENABLE, 32'h0000_0004, `RESP_OKAY, r);
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'h1, "irq raised")
        xfer(1, `ADDR_INT_CLEAR, 32'h0000_0004, `RESP_OKAY, r);
        repeat (3) @(posedge aclk);
        `CHK(irq, 1'h0, "irq cleared")
        $display("test soft start done");
        foreach (flt[i]) begin
            pin <= 11'(1 << flt[i]);
            settle(8, 0);
            pin <= 11'h000;
            settle(8, 0);
            if (i == 0) begin
                xfer(0, `ADDR_INT_STATUS, 0, `RESP_OKAY, r);
                `CHK(r[3:0], 4'h9, "overheat latch event")
                pin <= 11'h004;
                settle(8, 0);
                pin <= 11'h000;
                settle(8, 0);
                u_host.hold_low();
                settle(8, 0);
                u_host.drive(1'h1);
            end else begin
                pin <= 11'h00A;
                settle(8, 0);
                pin <= 11'h000;
            end
            settle(8, 0);
            settle(1400, 1);
        end
        $display("test latches done");
        pin <= 11'h002;
        settle(8, 0);
        pin <= 11'h000;
        u_host.drive(1'h0);
        settle(8, 0);
        pin <= 11'h004;
        u_host.drive(1'h1);
        settle(8, 0);
        pin <= 11'h080;
        settle(8, 0);
        settle(1400, 1);
        $display("test lockouts done");
        finish_test();
    end
endmodule : converter_mode_protection_fsm_test
`default_nettype wire
